//--- hw/iir_defs.vh
// iir_defs.vh: register offsets, field positions, reset values, counts
// assumes: included by bare name from every design file under hw/
`ifndef IIR_DEFS_VH
`define IIR_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define A_PWR 8'h00
`define A_OSR 8'h04
`define A_CFG 8'h08
`define A_FCFG 8'h0C
`define A_FCMD 8'h10
`define A_ISTAT 8'h14
`define A_IMASK 8'h18
`define A_TDATA 8'h1C
`define A_PDATA 8'h20
`define A_FDATA 8'h24
`define A_FLEN 8'h28
`define A_STIME 8'h2C
`define A_STAT 8'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define PWR_PEN 0
`define PWR_TEN 1
`define PWR_MODE_LO 4
`define PWR_MODE_HI 5
`define OSR_P_LO 0
`define OSR_P_HI 2
`define OSR_T_LO 3
`define OSR_T_HI 5
`define COEF_HI 6
`define FC_COLLECT 0
`define FC_STP 1
`define FC_STT 2
`define FC_TIME 3
`define FCMD_FLUSH 0
`define IS_DRDY 0
`define IS_FULL 1

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RST_PWR 6'h00
`define RST_OSR 6'h00
`define RST_CFG 7'h00
`define RST_FCFG 4'h0
`define RST_IMASK 2'h0
`define PWR_WMASK 6'h33
`define MODE_SLEEP 2'h0
`define MODE_NORMAL 2'h3
`define OSR_MAX 3'h5
`define HDR_EMPTY 8'h80
`define HDR_TIME 8'hA0
`define HDR_T 8'h10
`define HDR_P 8'h04

// ----------------------------------------
// sizes and counts
// ----------------------------------------
`define FIFO_BYTES 10'h200
`define FRAME_MAX 10'h009
`define DIV_STEPS 5'h1F

`endif

//--- hw/iir_chan.v
// iir_chan.v: one channel of the first-order smoothing filter
// assumes: samples come one at a time, never while busy is high
`timescale 1ns/1ps
`include "iir_defs.vh"

module iir_chan (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire clr,
	input wire [6:0] coef,
	input wire in_valid,
	input wire [23:0] in_data,
	output wire busy,
	output wire [23:0] out_data
);

reg seeded_ff;
reg run_ff;
reg [4:0] cnt_ff;
reg [30:0] num_ff;
reg [7:0] rem_ff;
reg [23:0] out_ff;
wire [7:0] den = {1'b0, coef} + 8'h01;
wire [8:0] trial = {rem_ff, num_ff[30]};
wire take = trial >= {1'b0, den};
wire [8:0] diff = trial - {1'b0, den};
wire [30:0] prod = out_ff * coef;

assign busy = run_ff;
assign out_data = out_ff;

// ----------------------------------------
// restoring divide, one quotient bit a cycle
// ----------------------------------------
always @(posedge clk or posedge reset) begin
	if (reset) begin
		seeded_ff <= 1'b0;
		run_ff <= 1'b0;
		cnt_ff <= 5'h00;
		num_ff <= 31'h0;
		rem_ff <= 8'h00;
		out_ff <= 24'h000000;
	end else if (ce) begin
		if (in_valid) begin
			if (!seeded_ff || clr || coef == 7'h00) begin
				out_ff <= in_data;
				seeded_ff <= 1'b1;
			end else begin
				num_ff <= prod + {7'h00, in_data};
				rem_ff <= 8'h00;
				cnt_ff <= `DIV_STEPS;
				run_ff <= 1'b1;
			end
		end else if (clr) begin
			seeded_ff <= 1'b0;
			run_ff <= 1'b0;
		end else if (run_ff) begin
			rem_ff <= take ? diff[7:0] : trial[7:0];
			num_ff <= {num_ff[29:0], take};
			cnt_ff <= cnt_ff - 5'h01;
			if (cnt_ff == 5'h01) begin
				run_ff <= 1'b0;
				out_ff <= {num_ff[22:0], take};
			end
		end
	end
end

endmodule

//--- hw/sample_fifo.v
// sample_fifo.v: byte-wide first-in-first-out store for frames
// assumes: push is never given while full, pop never while empty
`timescale 1ns/1ps
`include "iir_defs.vh"

module sample_fifo (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire flush,
	input wire push,
	input wire [7:0] wdata,
	input wire pop,
	output wire [7:0] rdata,
	output wire [9:0] count
);

reg [7:0] mem [0:511];
reg [8:0] wp_ff;
reg [8:0] rp_ff;
reg [9:0] cnt_ff;
wire do_push = push && cnt_ff != `FIFO_BYTES;
wire do_pop = pop && cnt_ff != 10'h000;

assign rdata = mem[rp_ff];
assign count = cnt_ff;

always @(posedge clk) begin
	if (ce && do_push && !flush) begin
		mem[wp_ff] <= wdata;
	end
end

// ----------------------------------------
// pointers; flush wins over both ends
// ----------------------------------------
always @(posedge clk or posedge reset) begin
	if (reset) begin
		wp_ff <= 9'h000;
		rp_ff <= 9'h000;
		cnt_ff <= 10'h000;
	end else if (ce) begin
		if (flush) begin
			wp_ff <= 9'h000;
			rp_ff <= 9'h000;
			cnt_ff <= 10'h000;
		end else begin
			if (do_push) begin
				wp_ff <= wp_ff + 9'h001;
			end
			if (do_pop) begin
				rp_ff <= rp_ff + 9'h001;
			end
			if (do_push && !do_pop) begin
				cnt_ff <= cnt_ff + 10'h001;
			end else if (do_pop && !do_push) begin
				cnt_ff <= cnt_ff - 10'h001;
			end
		end
	end
end

endmodule

//--- hw/sensor_post.v
// sensor_post.v: measurement sequencing, smoothing filters, frame buffer
// assumes: APB master and converter logic run on clk; meas_tick is the
// normal-mode sampling pulse from a rate timer on the same clock
`timescale 1ns/1ps
`include "iir_defs.vh"

module sensor_post (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire meas_tick,
	input wire conv_done,
	input wire [20:0] conv_data,
	output reg conv_start,
	output reg conv_temp,
	output reg [2:0] conv_osr,
	output reg irq
);

localparam S_IDLE = 5'h01;
localparam S_TEMP = 5'h02;
localparam S_PRESS = 5'h04;
localparam S_FILT = 5'h08;
localparam S_STORE = 5'h10;

reg [5:0] pwr_ff;
reg [5:0] osr_ff;
reg [6:0] coef_ff;
reg [3:0] fcfg_ff;
reg [1:0] imask_ff;
reg [1:0] istat_ff;
reg [23:0] tdata_ff;
reg [23:0] pdata_ff;
reg [23:0] stime_ff;
reg [23:0] tlat_ff;
reg [2:0] rdph_ff;
reg prev_ten_ff;
reg prev_pen_ff;
reg [1:0] prev_mode_ff;
reg full_prev_ff;
reg [4:0] state_ff;
reg t_vld_ff;
reg p_vld_ff;
reg meas_t_ff;
reg meas_p_ff;
reg [23:0] smp_ff;
reg [55:0] frame_ff;
reg [3:0] left_ff;
reg [31:0] rd_val;
reg rd_ok;
reg [7:0] fbyte;

wire [23:0] t_out;
wire [23:0] p_out;
wire t_busy;
wire p_busy;
wire [7:0] f_rdata;
wire [9:0] f_count;

// ----------------------------------------
// apb handshake
// ----------------------------------------
// one wait state: pready rises on the second access cycle
wire acc = psel && penable && !pready;
wire done_x = psel && penable && pready;
wire wr_done = done_x && pwrite && !pslverr;
wire rd_done = done_x && !pwrite;

wire [1:0] mode = pwr_ff[`PWR_MODE_HI:`PWR_MODE_LO];
wire ten = pwr_ff[`PWR_TEN];
wire pen = pwr_ff[`PWR_PEN];
wire forced = mode[1] ^ mode[0];
wire normal = mode == `MODE_NORMAL;

wire cfg_wr = wr_done && paddr == `A_CFG;
wire flush = wr_done && paddr == `A_FCMD && pwdata[`FCMD_FLUSH];
wire [9:0] free = `FIFO_BYTES - f_count;
wire full_lvl = free < `FRAME_MAX;
wire meas_end = state_ff == S_STORE && left_ff == 4'h0;
wire drdy_ev = state_ff == S_FILT && !t_busy && !p_busy &&
	!t_vld_ff && !p_vld_ff;

wire norm_rise = normal && prev_mode_ff == `MODE_SLEEP;
// clear on config write, entry to normal from sleep, or enable change
wire clr_t = cfg_wr || norm_rise || ten != prev_ten_ff;
wire clr_p = cfg_wr || norm_rise || pen != prev_pen_ff;

wire wr_active = fcfg_ff[`FC_COLLECT] &&
	(fcfg_ff[`FC_STP] || fcfg_ff[`FC_STT]);
wire t_in = fcfg_ff[`FC_STT] && meas_t_ff;
wire p_in = fcfg_ff[`FC_STP] && meas_p_ff;
wire [3:0] flen = 4'h1 + (t_in ? 4'h3 : 4'h0) + (p_in ? 4'h3 : 4'h0);
// data registers load at the same edge, so take the filter outputs
wire [23:0] tb = {t_out[7:0], t_out[15:8], t_out[23:16]};
wire [23:0] pb = {p_out[7:0], p_out[15:8], p_out[23:16]};
wire [7:0] hdr = `HDR_EMPTY | (t_in ? `HDR_T : 8'h00) |
	(p_in ? `HDR_P : 8'h00);
wire [55:0] frame = t_in ? (p_in ? {hdr, tb, pb} : {hdr, tb, 24'h0}) :
	{hdr, pb, 24'h0};

wire f_push = state_ff == S_STORE && left_ff != 4'h0;
wire f_pop = rd_done && paddr == `A_FDATA && f_count != 10'h000;
wire [2:0] eff_ph = (rdph_ff == 3'h0 && !fcfg_ff[`FC_TIME]) ?
	3'h4 : rdph_ff;

// keep 16 plus code bits (code capped at 5), rest zero
function [23:0] res_mask;
	input [2:0] code;
	reg [4:0] keep;
	begin
		keep = 5'h10 + {2'b00, (code > `OSR_MAX) ? `OSR_MAX : code};
		res_mask = ~(24'hFFFFFF >> keep);
	end
endfunction

// ----------------------------------------
// filter channels and buffer
// ----------------------------------------
// one state per channel
wire [1:0] ch_clr = {clr_p, clr_t};
wire [1:0] ch_vld = {p_vld_ff, t_vld_ff};
wire [1:0] ch_busy;
wire [47:0] ch_out;
assign t_busy = ch_busy[0];
assign p_busy = ch_busy[1];
assign t_out = ch_out[23:0];
assign p_out = ch_out[47:24];

genvar gi;
generate
for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
	iir_chan u_iir (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.clr(ch_clr[gi]),
		.coef(coef_ff),
		.in_valid(ch_vld[gi]),
		.in_data(smp_ff),
		.busy(ch_busy[gi]),
		.out_data(ch_out[gi*24 +: 24])
	);
end
endgenerate

sample_fifo u_fifo (
	.clk(clk),
	.reset(reset),
	.ce(ce),
	.flush(flush),
	.push(f_push),
	.wdata(frame_ff[55:48]),
	.pop(f_pop),
	.rdata(f_rdata),
	.count(f_count)
);

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
	fbyte = f_rdata;
	if (f_count == 10'h000) begin
		case (eff_ph)
		3'h0: fbyte = `HDR_TIME;
		3'h1: fbyte = tlat_ff[7:0];
		3'h2: fbyte = tlat_ff[15:8];
		3'h3: fbyte = tlat_ff[23:16];
		3'h4: fbyte = `HDR_EMPTY;
		default: fbyte = 8'h00;
		endcase
	end
	rd_ok = 1'b1;
	rd_val = 32'h0;
	case (paddr)
	`A_PWR: rd_val = {26'h0, pwr_ff};
	`A_OSR: rd_val = {26'h0, osr_ff};
	`A_CFG: rd_val = {25'h0, coef_ff};
	`A_FCFG: rd_val = {28'h0, fcfg_ff};
	`A_FCMD: rd_val = 32'h0;
	`A_ISTAT: rd_val = {30'h0, istat_ff};
	`A_IMASK: rd_val = {30'h0, imask_ff};
	`A_TDATA: rd_val = {8'h00, tdata_ff};
	`A_PDATA: rd_val = {8'h00, pdata_ff};
	`A_FDATA: rd_val = {24'h0, fbyte};
	`A_FLEN: rd_val = {22'h0, f_count};
	`A_STIME: rd_val = {8'h00, stime_ff};
	`A_STAT: rd_val = {28'h0, mode, wr_active, state_ff != S_IDLE};
	default: rd_ok = 1'b0;
	endcase
end

// ----------------------------------------
// bus slave and registers
// ----------------------------------------
always @(posedge clk or posedge reset) begin
	if (reset) begin
		pready <= 1'b0;
		prdata <= 32'h0;
		pslverr <= 1'b0;
		pwr_ff <= `RST_PWR;
		osr_ff <= `RST_OSR;
		coef_ff <= `RST_CFG;
		fcfg_ff <= `RST_FCFG;
		imask_ff <= `RST_IMASK;
	end else if (ce) begin
		pready <= acc;
		if (acc) begin
			prdata <= pwrite ? 32'h0 : rd_val;
			pslverr <= !rd_ok;
		end
		if (wr_done && paddr == `A_PWR) begin
			pwr_ff <= pwdata[5:0] & `PWR_WMASK;
		end else if (meas_end && forced) begin
			// forced run over, back to sleep
			pwr_ff[`PWR_MODE_HI:`PWR_MODE_LO] <= `MODE_SLEEP;
		end
		if (wr_done && paddr == `A_OSR) begin
			osr_ff <= pwdata[5:0];
		end
		if (cfg_wr) begin
			coef_ff <= pwdata[`COEF_HI:0];
		end
		if (wr_done && paddr == `A_FCFG) begin
			fcfg_ff <= pwdata[3:0];
		end
		if (wr_done && paddr == `A_IMASK) begin
			imask_ff <= pwdata[1:0];
		end
	end
end

// ----------------------------------------
// status, interrupt, read-out phase
// ----------------------------------------
// evaluated whether or not writing is active
wire [1:0] ev = {full_lvl && !full_prev_ff, drdy_ev};
wire [1:0] rd_clr = (rd_done && paddr == `A_ISTAT) ? prdata[1:0] : 2'h0;
// set wins over the read clear
wire [1:0] nxt_istat = (istat_ff & ~rd_clr) | ev;

always @(posedge clk or posedge reset) begin
	if (reset) begin
		istat_ff <= 2'h0;
		irq <= 1'b0;
		full_prev_ff <= 1'b0;
		stime_ff <= 24'h000000;
		tlat_ff <= 24'h000000;
		rdph_ff <= 3'h0;
		prev_ten_ff <= 1'b0;
		prev_pen_ff <= 1'b0;
		prev_mode_ff <= `MODE_SLEEP;
	end else if (ce) begin
		istat_ff <= nxt_istat;
		irq <= |(nxt_istat & imask_ff);
		full_prev_ff <= full_lvl;
		stime_ff <= stime_ff + 24'h000001;
		prev_ten_ff <= ten;
		prev_pen_ff <= pen;
		prev_mode_ff <= mode;
		if (flush || f_count != 10'h000) begin
			rdph_ff <= 3'h0;
		end else if (rd_done && paddr == `A_FDATA) begin
			// time payload is the counter at header read
			if (eff_ph == 3'h0) begin
				tlat_ff <= stime_ff;
			end
			rdph_ff <= (eff_ph == 3'h5) ? 3'h4 : eff_ph + 3'h1;
		end
	end
end

// ----------------------------------------
// measurement sequencer
// ----------------------------------------
always @(posedge clk or posedge reset) begin
	if (reset) begin
		state_ff <= S_IDLE;
		conv_start <= 1'b0;
		conv_temp <= 1'b0;
		conv_osr <= 3'h0;
		t_vld_ff <= 1'b0;
		p_vld_ff <= 1'b0;
		meas_t_ff <= 1'b0;
		meas_p_ff <= 1'b0;
		smp_ff <= 24'h000000;
		frame_ff <= 56'h0;
		left_ff <= 4'h0;
		tdata_ff <= 24'h000000;
		pdata_ff <= 24'h000000;
	end else if (ce) begin
		conv_start <= 1'b0;
		t_vld_ff <= 1'b0;
		p_vld_ff <= 1'b0;
		case (state_ff)
		S_IDLE: begin
			meas_t_ff <= 1'b0;
			meas_p_ff <= 1'b0;
			if (forced || (normal && meas_tick)) begin
				if (ten) begin
					conv_start <= 1'b1;
					conv_temp <= 1'b1;
					conv_osr <= osr_ff[`OSR_T_HI:`OSR_T_LO];
					state_ff <= S_TEMP;
				end else if (pen) begin
					conv_start <= 1'b1;
					conv_temp <= 1'b0;
					conv_osr <= osr_ff[`OSR_P_HI:`OSR_P_LO];
					state_ff <= S_PRESS;
				end else begin
					state_ff <= S_FILT;
				end
			end
		end
		S_TEMP: begin
			if (conv_done) begin
				smp_ff <= {conv_data, 3'h0} &
					res_mask(osr_ff[`OSR_T_HI:`OSR_T_LO]);
				t_vld_ff <= 1'b1;
				meas_t_ff <= 1'b1;
				if (pen) begin
					conv_start <= 1'b1;
					conv_temp <= 1'b0;
					conv_osr <= osr_ff[`OSR_P_HI:`OSR_P_LO];
					state_ff <= S_PRESS;
				end else begin
					state_ff <= S_FILT;
				end
			end
		end
		S_PRESS: begin
			if (conv_done && !t_busy && !t_vld_ff) begin
				smp_ff <= {conv_data, 3'h0} &
					res_mask(osr_ff[`OSR_P_HI:`OSR_P_LO]);
				p_vld_ff <= 1'b1;
				meas_p_ff <= 1'b1;
				state_ff <= S_FILT;
			end
		end
		S_FILT: begin
			if (drdy_ev) begin
				if (meas_t_ff) begin
					tdata_ff <= t_out;
				end
				if (meas_p_ff) begin
					pdata_ff <= p_out;
				end
				state_ff <= S_STORE;
			end
		end
		S_STORE: begin
			if (left_ff != 4'h0) begin
				frame_ff <= {frame_ff[47:0], 8'h00};
				left_ff <= left_ff - 4'h1;
			end else begin
				state_ff <= S_IDLE;
			end
		end
		default: state_ff <= S_IDLE;
		endcase
		// only whole frames, only while active
		if (drdy_ev) begin
			frame_ff <= frame;
			left_ff <= (wr_active && (t_in || p_in) &&
				free >= {6'h00, flen}) ? flen : 4'h0;
		end
	end
end

endmodule

//--- dv/conv_model.sv
// conv_model.sv: converter stand-in answering each conv_start
// assumes: one conversion at a time, sample values set by the bench
`timescale 1ns/1ps
module conv_model #(parameter int DLY = 40) (
	input wire logic clk,
	input wire logic reset,
	input wire logic conv_start,
	input wire logic conv_temp,
	input wire logic [20:0] t_val,
	input wire logic [20:0] p_val,
	output logic conv_done,
	output logic [20:0] conv_data
);
	int cnt_ff;
	logic tsel_ff;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 0;
			tsel_ff <= 1'b0;
			conv_done <= 1'b0;
			conv_data <= 21'h0;
		end else begin
			if (conv_start) begin
				cnt_ff <= DLY;
				tsel_ff <= conv_temp;
			end else if (cnt_ff != 0) begin
				cnt_ff <= cnt_ff - 1;
			end
			conv_done <= cnt_ff == 1 && !conv_start;
			// idle data toggles so a stale value never looks valid
			conv_data <= (cnt_ff == 1) ? (tsel_ff ? t_val : p_val) : ~conv_data;
		end
	end
endmodule

//--- dv/sensor_post_sva.sv
// sensor_post_sva.sv: port-level checks of sensor_post
// assumes: bound into sensor_post; settings mirrored from APB writes
`timescale 1ns/1ps
module sensor_post_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic meas_tick,
	input wire logic conv_done,
	input wire logic [20:0] conv_data,
	input wire logic conv_start,
	input wire logic conv_temp,
	input wire logic [2:0] conv_osr,
	input wire logic irq
);
	logic [5:0] pwr_ff;
	logic [2:0] tosr_ff;
	logic [2:0] posr_ff;
	logic [1:0] msk_ff;
	logic pend_ff;
	logic wr_ok;
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pwr_ff <= 6'h00;
			tosr_ff <= 3'h0;
			posr_ff <= 3'h0;
			msk_ff <= 2'h0;
			pend_ff <= 1'b0;
		end else if (ce) begin
			if (wr_ok && paddr == 8'h00)
				pwr_ff <= pwdata[5:0] & 6'h33;
			if (wr_ok && paddr == 8'h04)
				tosr_ff <= pwdata[5:3];
			if (wr_ok && paddr == 8'h04)
				posr_ff <= pwdata[2:0];
			if (wr_ok && paddr == 8'h18)
				msk_ff <= pwdata[1:0];
			if (conv_start)
				pend_ff <= 1'b1;
			else if (conv_done)
				pend_ff <= 1'b0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset || !ce);
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_decode: assert property (psel && penable && !pready
		|=> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h30))
		else $error("pslverr decode wrong");
	a_err_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	a_chan_gate: assert property (conv_start |->
		(conv_temp ? pwr_ff[1] : pwr_ff[0])) else $error("channel gate");
	a_temp_osr: assert property (conv_start && conv_temp |->
		conv_osr == tosr_ff) else $error("temperature code wrong");
	a_press_osr: assert property (conv_start && !conv_temp |->
		conv_osr == posr_ff) else $error("pressure code wrong");
	a_no_sleep: assert property (conv_start |-> pwr_ff[5:4] != 2'h0)
		else $error("conversion in sleep");
	a_press_next: assert property (conv_done && pend_ff && conv_temp
		&& pwr_ff[0] |=> conv_start && !conv_temp)
		else $error("pressure not started");
	a_irq_mask: assert property (irq |-> msk_ff != 2'h0
		|| $past(msk_ff) != 2'h0) else $error("irq while masked");
endmodule
bind sensor_post sensor_post_sva chk_u (
	.clk(clk), .reset(reset), .ce(ce), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.meas_tick(meas_tick), .conv_done(conv_done), .conv_data(conv_data),
	.conv_start(conv_start), .conv_temp(conv_temp), .conv_osr(conv_osr),
	.irq(irq)
);

//--- dv/oversample_iir_fifo_enable_test.sv
// oversample_iir_fifo_enable_test.sv: self-checking bench for sensor_post
// assumes: conv_model answers conversions; checker bound in its own file
`timescale 1ns/1ps
module oversample_iir_fifo_enable_test;
	logic clk, reset, ce, psel, penable, pwrite, meas_tick;
	logic pready, pslverr, conv_done, conv_start, conv_temp, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [20:0] conv_data, t_val, p_val;
	logic [2:0] conv_osr;
	logic [23:0] v;
	int n_errors, n_compared, cyc;
	sensor_post dut_u (.clk(clk), .reset(reset), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_tick(meas_tick), .conv_done(conv_done), .conv_data(conv_data),
		.conv_start(conv_start), .conv_temp(conv_temp),
		.conv_osr(conv_osr), .irq(irq));
	conv_model conv_u (.clk(clk), .reset(reset), .conv_start(conv_start),
		.conv_temp(conv_temp), .t_val(t_val), .p_val(p_val),
		.conv_done(conv_done), .conv_data(conv_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ceiling well above the roughly 9k cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic close_out();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(a, 1'b1, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
		input logic ex = 1'b0);
		logic [31:0] q;
		logic e;
		apb(a, 1'b0, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, ex});
	endtask
	// forced or normal measurement, waits until idle and mode settled
	task automatic meas(input logic [7:0] pw, input logic [20:0] t,
		input logic [20:0] p);
		logic [31:0] q;
		logic e;
		t_val <= t;
		p_val <= p;
		wr(8'h00, {24'h0, pw});
		if (pw[5:4] == 2'h3) begin
			meas_tick <= 1'b1;
			@(posedge clk);
			meas_tick <= 1'b0;
		end
		q = 32'h1;
		while (q[0] !== 1'b0 || q[3:2] == 2'h1 || q[3:2] == 2'h2)
			apb(8'h30, 1'b0, 32'h0, q, e);
	endtask
	function automatic logic [23:0] rw(input int c, input logic [20:0] s);
		rw = {s, 3'h0} & ~((24'h1 << (8 - c)) - 24'h1);
	endfunction
	function automatic logic [23:0] flt(input logic [23:0] o,
		input logic [23:0] n, input int k);
		flt = 24'((o * k + n) / (k + 1));
	endfunction
	task automatic t_regs();
		logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h28};
		foreach (ra[i])
			rdc(ra[i], 32'h0);
		wr(8'h34, 32'hFF);
		rdc(8'h34, 32'h0, 1'b1);
		rdc(8'h02, 32'h0, 1'b1);
		wr(8'h28, 32'h5);
		rdc(8'h28, 32'h0);
		wr(8'h00, 32'h0F);
		rdc(8'h00, 32'h03);
		wr(8'h00, 32'h0);
	endtask
	// reads of the counter are four cycles apart; a frozen gap adds none
	task automatic t_hold();
		logic [31:0] a, b, c;
		logic e;
		apb(8'h2C, 1'b0, 32'h0, a, e);
		apb(8'h2C, 1'b0, 32'h0, b, e);
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		apb(8'h2C, 1'b0, 32'h0, c, e);
		chk(b - a, 32'h4);
		chk(c - b, 32'h4);
	endtask
	task automatic t_osr();
		for (int c = 0; c < 6; c++) begin
			wr(8'h04, 32'(c << 3));
			meas(8'h12, 21'h1A5A5B, 21'h0);
			rdc(8'h1C, {8'h0, rw(c, 21'h1A5A5B)});
		end
		meas(8'h11, 21'h0F0F0F, 21'h135799);
		rdc(8'h1C, {8'h0, rw(5, 21'h1A5A5B)});
		rdc(8'h20, {8'h0, rw(0, 21'h135799)});
	endtask
	task automatic t_filt();
		wr(8'h04, 32'h09);
		wr(8'h08, 32'h7F);
		meas(8'h13, 21'h100003, 21'h0ABCDE);
		rdc(8'h1C, {8'h0, rw(1, 21'h100003)});
		rdc(8'h20, {8'h0, rw(1, 21'h0ABCDE)});
		meas(8'h13, 21'h1F0001, 21'h05A5A5);
		v = flt(rw(1, 21'h100003), rw(1, 21'h1F0001), 127);
		rdc(8'h1C, {8'h0, v});
		v = flt(rw(1, 21'h0ABCDE), rw(1, 21'h05A5A5), 127);
		rdc(8'h20, {8'h0, v});
		wr(8'h08, 32'h7F);
		meas(8'h13, 21'h022222, 21'h033333);
		rdc(8'h1C, {8'h0, rw(1, 21'h022222)});
		wr(8'h00, 32'h01);
		meas(8'h13, 21'h144444, 21'h033333);
		rdc(8'h1C, {8'h0, rw(1, 21'h144444)});
		meas(8'h33, 21'h0DDDDD, 21'h1EEEEE);
		rdc(8'h1C, {8'h0, rw(1, 21'h0DDDDD)});
		rdc(8'h20, {8'h0, rw(1, 21'h1EEEEE)});
		wr(8'h00, 32'h03);
		meas_tick <= 1'b1;
		@(posedge clk);
		meas_tick <= 1'b0;
		rdc(8'h30, 32'h0);
	endtask
	task automatic t_irq();
		logic [31:0] q;
		logic e;
		apb(8'h14, 1'b0, 32'h0, q, e);
		wr(8'h18, 32'h1);
		meas(8'h12, 21'h00ABCD, 21'h0);
		chk({31'h0, irq}, 32'h1);
		rdc(8'h14, 32'h1);
		rdc(8'h14, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h18, 32'h0);
		meas(8'h22, 21'h00ABCD, 21'h0);
		chk({31'h0, irq}, 32'h0);
		rdc(8'h14, 32'h1);
	endtask
	task automatic t_fifo();
		logic [31:0] q;
		logic e;
		v = rw(1, 21'h1C3A5F);
		wr(8'h08, 32'h0);
		wr(8'h10, 32'h1);
		wr(8'h0C, 32'h05);
		meas(8'h12, 21'h1C3A5F, 21'h0);
		rdc(8'h28, 32'h4);
		wr(8'h0C, 32'h04);
		meas(8'h12, 21'h0, 21'h0);
		rdc(8'h28, 32'h4);
		rdc(8'h24, 32'h90);
		rdc(8'h24, {24'h0, v[7:0]});
		rdc(8'h24, {24'h0, v[15:8]});
		rdc(8'h24, {24'h0, v[23:16]});
		rdc(8'h24, 32'h80);
		rdc(8'h24, 32'h00);
		wr(8'h0C, 32'h08);
		wr(8'h10, 32'h1);
		rdc(8'h24, 32'hA0);
		repeat (3)
			apb(8'h24, 1'b0, 32'h0, q, e);
		rdc(8'h24, 32'h80);
		wr(8'h0C, 32'h01);
		meas(8'h12, 21'h0, 21'h0);
		rdc(8'h28, 32'h0);
		wr(8'h0C, 32'h05);
		for (int i = 0; i < 130; i++)
			meas(8'h12, 21'(i), 21'h0);
		rdc(8'h28, 32'h200);
		wr(8'h0C, 32'h0);
		rdc(8'h14, 32'h3);
		wr(8'h10, 32'h1);
		rdc(8'h28, 32'h0);
	endtask
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		meas_tick = 1'b0;
		t_val = 21'h0;
		p_val = 21'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_regs();
		t_hold();
		t_osr();
		t_filt();
		t_irq();
		t_fifo();
		close_out();
	end
endmodule
